/* File: shared/udc_pkg.sv */
// Package for the dual-input up/down counter: widths, limits and carriers
package udc_pkg;
   localparam int unsigned COUNT_W = 4;
   localparam logic [3:0] DECADE_MAX = 4'h9;
   localparam logic [3:0] BINARY_MAX = 4'hf;
   localparam logic [3:0] COUNT_RST = 4'h0;
   localparam logic [1:0] EDGE_RST = 2'h3;

   // Count-pin levels, up in bit 1, down in bit 0
   typedef struct packed {
      logic up;
      logic down;
   } udc_pins_t;

   // Cascade outputs, both active low
   typedef struct packed {
      logic carry_n;
      logic borrow_n;
   } udc_casc_t;

   typedef enum logic [1:0] {
      UDC_HOLD,
      UDC_INC,
      UDC_DEC
   } udc_step_t;
endpackage : udc_pkg

/* File: rtl/udc_next.sv */
// Next-count arithmetic with wrap for decade and binary variants
module udc_next #(
   parameter bit DECADE = 1'b1
) (
   // Present state and step
   input wire logic [3:0] count_in,
   input wire udc_pkg::udc_step_t step_in,
   // Result
   output logic [3:0] next_out,
   output logic at_max_out,
   output logic at_zero_out
);
   wire logic [3:0] max_val = DECADE ? udc_pkg::DECADE_MAX : udc_pkg::BINARY_MAX;
   // illegal codes escape
   // Any decade value above nine counts up to zero in one step, down to eight.
   wire logic above_max = DECADE && (count_in > udc_pkg::DECADE_MAX);
   wire logic [3:0] inc_val = (count_in == max_val || above_max) ? 4'h0 : 4'(count_in + 4'h1);
   wire logic [3:0] dec_val = (count_in == 4'h0) ? max_val :
      (above_max ? 4'(udc_pkg::DECADE_MAX - 4'h1) : 4'(count_in - 4'h1));

   assign at_max_out = (count_in == max_val);
   assign at_zero_out = (count_in == 4'h0);
   assign next_out = (step_in == udc_pkg::UDC_INC) ? inc_val :
      ((step_in == udc_pkg::UDC_DEC) ? dec_val : count_in);
endmodule : udc_next

/* File: rtl/udc_counter.sv */
// Dual-input reversible 4-bit counter with preset, zeroing and cascade outputs
// Overview of operation
// - Four-bit count, decade or binary by parameter
// - All count bits update on one edge
// - Count steps up or down only on a count-pin rising edge
// - Up edge increments, down edge decrements
// - Load low copies preset data into count
// - Zeroing input high forces count to zero
// - Zeroing beats load, data and count pins
// - Borrow low at zero with down low
// - Carry low at maximum with up low
// - Decade wraps nine to zero and back
// - Binary wraps fifteen to zero and back
module udc_counter #(
   parameter bit DECADE = 1'b1,
   parameter int unsigned WIDTH = udc_pkg::COUNT_W
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic reset_n_in,
   // Count pins, sampled on clock_in
   input wire logic count_up_in,
   input wire logic count_down_in,
   // Preset and zeroing
   input wire logic load_n_in,
   input wire logic [3:0] preset_data_in,
   input wire logic zeroing_input_in,
   // Count and cascade outputs
   output logic [3:0] count_out,
   output logic carry_out_n_out,
   output logic borrow_out_n_out
);
   // Timing summary for users of this block:
   // The count pins are levels sampled on clock_in, so an edge is seen one clock after the pin rises.
   // A pin must therefore sit low for at least one clock and then high for at least one clock.
   // At most one step per two clocks per pin is possible; faster toggling is lost, not queued.
   // Load and zeroing are taken at the next clock edge rather than at once.
   // This trades the asynchronous preset of a discrete part for a single clean clock domain.
   // Carry and borrow are registered, so they follow the count by no extra cycle,
   // but a cascaded stage sees its own count pin rise one clock after this stage counted.
   // A chain of N stages therefore settles N-1 clocks after the first stage steps.
   // Decade codes ten to fifteen can only appear through a preset.
   // They hold until a step arrives, which returns them to the legal range at once.

   initial begin
      if (WIDTH != 4) begin
         $error("udc_counter supports only a 4-bit count");
      end
   end

   udc_pkg::udc_pins_t pins_q;
   udc_pkg::udc_pins_t pins_now;
   udc_pkg::udc_casc_t casc_q;
   udc_pkg::udc_casc_t casc_d;
   udc_pkg::udc_step_t step;
   logic [3:0] count_q;
   logic [3:0] count_d;
   logic [3:0] next_val;
   logic at_max;
   logic at_zero;

   assign pins_now = '{up: count_up_in, down: count_down_in};

   // rising edges only
   // Pins are treated as clock-synchronous levels; an edge is a low-to-high step between samples.
   wire logic up_rise = pins_now.up && !pins_q.up;
   wire logic down_rise = pins_now.down && !pins_q.down;
   // opposite pin must be high
   // Both rising together, or the idle pin low, leaves the count alone.
   assign step = (up_rise && pins_now.down && !down_rise) ? udc_pkg::UDC_INC :
      ((down_rise && pins_now.up && !up_rise) ? udc_pkg::UDC_DEC : udc_pkg::UDC_HOLD);

   udc_next #(
      .DECADE(DECADE)
   ) u_next (
      .count_in(count_q),
      .step_in(step),
      .next_out(next_val),
      .at_max_out(at_max),
      .at_zero_out(at_zero)
   );

   // load copies data
   // Load and zeroing act at the next clock edge; a true asynchronous path is not available here.
   assign count_d = zeroing_input_in ? udc_pkg::COUNT_RST :
      (!load_n_in ? preset_data_in : next_val);

   // Cascade flags are computed from the next count so they line up with count_out.
   wire logic next_max = (count_d == (DECADE ? udc_pkg::DECADE_MAX : udc_pkg::BINARY_MAX));
   wire logic next_zero = (count_d == 4'h0);
   // carry at maximum with up low
   // borrow at zero with down low
   assign casc_d = '{carry_n: !(next_max && !count_up_in), borrow_n: !(next_zero && !count_down_in)};

   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         count_q <= udc_pkg::COUNT_RST;
         pins_q <= udc_pkg::EDGE_RST;
         casc_q <= 2'h3;
      end else begin
         count_q <= count_d;
         pins_q <= pins_now;
         casc_q <= casc_d;
      end
   end

   assign count_out = count_q;
   assign carry_out_n_out = casc_q.carry_n;
   assign borrow_out_n_out = casc_q.borrow_n;

   AST_RANGE: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (DECADE && $past(count_q) <= 4'h9 && $past(load_n_in) && $past(reset_n_in)) |-> count_q <= 4'h9)
      else $error("decade count left legal range");

   AST_ZERO: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      zeroing_input_in |=> count_q == 4'h0)
      else $error("zeroing did not clear count");

   AST_PRIO: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (zeroing_input_in && !load_n_in && preset_data_in != 4'h0) |=> count_q == 4'h0)
      else $error("load beat zeroing");

   AST_LOAD: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (!zeroing_input_in && !load_n_in) |=> count_q == $past(preset_data_in))
      else $error("preset not loaded");

   AST_STILL: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (load_n_in && !zeroing_input_in && !(count_up_in && !pins_q.up) && !(count_down_in && !pins_q.down))
      |=> $stable(count_q))
      else $error("count moved without a rising edge");

   AST_INC: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (load_n_in && !zeroing_input_in && count_up_in && !pins_q.up && pins_q.down && count_down_in
       && count_q != (DECADE ? 4'h9 : 4'hf) && count_q < (DECADE ? 4'h9 : 4'hf))
      |=> count_q == $past(count_q) + 4'h1)
      else $error("up edge did not increment");

   AST_WRAP_UP: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (load_n_in && !zeroing_input_in && step == udc_pkg::UDC_INC && at_max) |=> count_q == 4'h0)
      else $error("up wrap failed");

   AST_WRAP_DN: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (load_n_in && !zeroing_input_in && step == udc_pkg::UDC_DEC && at_zero)
      |=> count_q == (DECADE ? 4'h9 : 4'hf))
      else $error("down wrap failed");

   AST_BORROW: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      !borrow_out_n_out |-> (count_q == 4'h0 && !$past(count_down_in)))
      else $error("borrow low without zero and down low");

   AST_CARRY: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      !carry_out_n_out |-> (count_q == (DECADE ? 4'h9 : 4'hf) && !$past(count_up_in)))
      else $error("carry low without maximum and up low");

   AST_ESCAPE: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (DECADE && load_n_in && !zeroing_input_in && count_q > 4'h9 && step != udc_pkg::UDC_HOLD)
      |=> count_q <= 4'h9)
      else $error("illegal decade code not escaped");

   AST_DEC: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (load_n_in && !zeroing_input_in && step == udc_pkg::UDC_DEC && count_q != 4'h0 && count_q <= 4'h9)
      |=> count_q == 4'(($past(count_q) - 4'h1)))
      else $error("down edge did not decrement");

   AST_BOTH: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (load_n_in && !zeroing_input_in && up_rise && down_rise) |=> $stable(count_q))
      else $error("count moved on two edges at once");

   // up edge with down pin low refused
   AST_IDLE_LOW: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (load_n_in && !zeroing_input_in && up_rise && !count_down_in) |=> $stable(count_q))
      else $error("up edge counted while down pin low");

   AST_CARRY_SET: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (next_max && !count_up_in) |=> !carry_out_n_out)
      else $error("carry not driven low at maximum");

   AST_BORROW_SET: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (next_zero && !count_down_in) |=> !borrow_out_n_out)
      else $error("borrow not driven low at zero");

   AST_CARRY_HI: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      count_up_in |=> carry_out_n_out)
      else $error("carry low while up pin high");

   AST_BORROW_HI: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      count_down_in |=> borrow_out_n_out)
      else $error("borrow low while down pin high");

   AST_ESC_DN: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (DECADE && load_n_in && !zeroing_input_in && count_q > 4'h9 && step == udc_pkg::UDC_DEC)
      |=> count_q == 4'h8)
      else $error("illegal decade code did not step down to eight");

   AST_RST: assert property (@(posedge clock_in)
      !reset_n_in |=> (count_q == 4'h0 && carry_out_n_out && borrow_out_n_out))
      else $error("reset did not clear count and cascade");
endmodule : udc_counter

/* File: test/udc_pin_drv.sv */
// Far-side driving logic that drives each count pin low for each cycle its own request is high
module udc_pin_drv (
   // Clock and requests
   input wire logic clock_in,
   input wire logic step_up_in,
   input wire logic step_down_in,
   // Count pins
   output logic count_up_out,
   output logic count_down_out
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge clock_in) begin
      count_up_out <= ~step_up_in;
      count_down_out <= ~step_down_in;
   end
endmodule : udc_pin_drv

/* File: test/tb.sv */
// Self-checking bench running decade and binary counters side by side
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic step_up = 1'b0;
   logic step_down = 1'b0;
   logic load_n_in = 1'b1;
   logic [3:0] preset_data_in = 4'h0;
   logic zeroing_input_in = 1'b0;
   logic count_up;
   logic count_down;
   logic [3:0] cnt_dec;
   logic [3:0] cnt_bin;
   udc_pkg::udc_casc_t casc_dec;
   udc_pkg::udc_casc_t casc_bin;
   logic [3:0] cnt_next;
   int errors = 0;
   int samples_checked = 0;

   udc_pin_drv PARTNER (.clock_in(clock_in), .step_up_in(step_up), .step_down_in(step_down),
      .count_up_out(count_up), .count_down_out(count_down));
   udc_counter #(.DECADE(1'b1)) DUT (.clock_in(clock_in), .reset_n_in(reset_n_in), .count_up_in(count_up),
      .count_down_in(count_down), .load_n_in(load_n_in), .preset_data_in(preset_data_in),
      .zeroing_input_in(zeroing_input_in), .count_out(cnt_dec), .carry_out_n_out(casc_dec.carry_n),
      .borrow_out_n_out(casc_dec.borrow_n));
   udc_counter #(.DECADE(1'b0)) DUT_BIN (.clock_in(clock_in), .reset_n_in(reset_n_in), .count_up_in(count_up),
      .count_down_in(count_down), .load_n_in(load_n_in), .preset_data_in(preset_data_in),
      .zeroing_input_in(zeroing_input_in), .count_out(cnt_bin), .carry_out_n_out(casc_bin.carry_n),
      .borrow_out_n_out(casc_bin.borrow_n));
   udc_counter #(.DECADE(1'b1)) DUT_NEXT (.clock_in(clock_in), .reset_n_in(reset_n_in),
      .count_up_in(casc_dec.carry_n), .count_down_in(casc_dec.borrow_n), .load_n_in(load_n_in),
      .preset_data_in(preset_data_in), .zeroing_input_in(zeroing_input_in), .count_out(cnt_next),
      .carry_out_n_out(), .borrow_out_n_out());

   initial begin
      forever #50 clock_in = ~clock_in;
   end

   task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Cascade is judged just after the pin rises, as registered while it was low; counts one clock after its rise
   task automatic pulse(input logic up, input logic down, input logic [3:0] e_dec, input logic [3:0] e_bin,
      input logic [1:0] casc_low);
      @(posedge clock_in);
      step_up <= up;
      step_down <= down;
      @(posedge clock_in);
      step_up <= 1'b0;
      step_down <= 1'b0;
      @(posedge clock_in);
      #1;
      chk("cascade", {casc_low, casc_low}, {casc_dec, casc_bin});
      @(posedge clock_in);
      #1;
      chk("count decade", e_dec, cnt_dec);
      chk("count binary", e_bin, cnt_bin);
      chk("cascade idle", 4'hf, {casc_dec, casc_bin});
   endtask : pulse

   task automatic preset(input logic zero, input logic [3:0] data, input logic [3:0] exp);
      @(posedge clock_in);
      load_n_in <= 1'b0;
      preset_data_in <= data;
      zeroing_input_in <= zero;
      @(posedge clock_in);
      load_n_in <= 1'b1;
      zeroing_input_in <= 1'b0;
      #1;
      chk("preset", {exp, exp}, {cnt_dec, cnt_bin});
   endtask : preset

   task automatic test_reset();
      @(posedge clock_in);
      #1;
      chk("reset", 4'h0, cnt_dec | cnt_bin);
   endtask : test_reset

   task automatic test_wrap();
      pulse(1'b0, 1'b1, 4'h9, 4'hf, 2'h2);
      pulse(1'b1, 1'b0, 4'h0, 4'h0, 2'h1);
   endtask : test_wrap

   task automatic test_priority();
      preset(1'b1, 4'h5, 4'h0);
      preset(1'b0, 4'h7, 4'h7);
      pulse(1'b1, 1'b0, 4'h8, 4'h8, 2'h3);
      pulse(1'b1, 1'b1, 4'h8, 4'h8, 2'h3);
   endtask : test_priority

   task automatic test_illegal();
      preset(1'b0, 4'hc, 4'hc);
      pulse(1'b1, 1'b0, 4'h0, 4'hd, 2'h3);
      preset(1'b0, 4'hc, 4'hc);
      pulse(1'b0, 1'b1, 4'h8, 4'hb, 2'h3);
   endtask : test_illegal

   // Next stage counts one clock after the first stage's cascade pulse ends
   task automatic test_cascade();
      preset(1'b0, 4'h0, 4'h0);
      pulse(1'b0, 1'b1, 4'h9, 4'hf, 2'h2);
      @(posedge clock_in);
      #1;
      chk("next stage down", 4'h9, cnt_next);
      pulse(1'b1, 1'b0, 4'h0, 4'h0, 2'h1);
      @(posedge clock_in);
      #1;
      chk("next stage up", 4'h0, cnt_next);
      preset(1'b0, 4'h7, 4'h7);
      @(posedge clock_in);
      zeroing_input_in <= 1'b1;
      @(posedge clock_in);
      zeroing_input_in <= 1'b0;
      #1;
      chk("zeroing", 4'h0, cnt_dec | cnt_bin | cnt_next);
   endtask : test_cascade

   task automatic final_report();
      if (errors == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report

   initial begin
      repeat (16) @(posedge clock_in);
      reset_n_in <= 1'b1;
      test_reset();
      test_wrap();
      test_priority();
      test_illegal();
      test_cascade();
      final_report();
   end
endmodule : tb
